// *** design/mswd_pkg.sv ***
// Constants for the millisecond watchdog: register map, fields, resets.
// Assumes a plain register port with word indices and a single system clock.
package mswd_pkg;

    // ------------------------------------------------------------
    // Register map (word indices)
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_TIMEOUT   = 8'hd6;
    localparam logic [7:0]  ADDR_DISABLE   = 8'hd7;
    localparam logic [7:0]  ADDR_FREQ      = 8'he0;   // Oscillator MHz
    localparam logic [7:0]  ADDR_IRQ_STAT  = 8'he1;
    localparam logic [7:0]  ADDR_IRQ_MASK  = 8'he2;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int          TIMEOUT_W      = 16;
    localparam int          FREQ_W         = 7;
    localparam int          PRESC_W        = 17;
    localparam logic [15:0] TIMEOUT_RST    = 16'h03e8;
    localparam logic [15:0] COUNT_RST      = 16'h0000;   // Live count reads zero until loaded
    localparam logic [31:0] DISABLE_MAGIC  = 32'h0d15ab1e;
    localparam logic [31:0] ENABLE_VALUE   = 32'h00000000;
    localparam logic [6:0]  FREQ_RST       = 7'h19;     // 25 MHz
    localparam logic [6:0]  FREQ_MIN       = 7'h05;
    localparam logic [6:0]  FREQ_MAX       = 7'h64;
    localparam logic [9:0]  CLK_PER_MHZ_MS = 10'h3e8;   // 1000 clocks per MHz per ms

    // Status bit positions
    localparam int          IRQ_EXPIRE     = 0;
    localparam int          IRQ_NACK       = 1;
    localparam int          IRQ_W          = 2;

    // Tile reset pulse length in system clocks
    localparam logic [3:0]  TILE_RST_CYC   = 4'h8;

endpackage

// *** design/mswd_top.sv ***
// Millisecond watchdog: prescaler, countdown, keyed register file.
// Assumes a single-cycle register master on sys_clk; power state arrives
// from another domain and is synchronised here.
`timescale 1ns/1ps

module mswd_top
    import mswd_pkg::*;
(
    input  wire logic        sys_clk,         // System clock, 125 MHz
    input  wire logic        rst,             // Async reset, active high
    input  wire logic [7:0]  reg_addr,        // Register word index
    input  wire logic [31:0] reg_wdata,       // Write data
    input  wire logic        reg_wr,          // Write strobe
    input  wire logic        reg_rd,          // Read strobe
    output logic      [31:0] reg_rdata,       // Read data, cycle after strobe
    output logic             reg_ack,         // Write accepted, cycle after strobe
    output logic             reg_nack,        // Write refused, cycle after strobe
    input  wire logic        full_power_state,// Device fully full_power_state, async
    output logic             tile_reset,      // Processor tile reset
    output logic             irq              // Level interrupt
);

    // ------------------------------------------------------------
    // Power state synchroniser
    // ------------------------------------------------------------
    logic full_power_state_meta_q;
    logic full_power_state_q;

    // Two stages; only full_power_state_q is read by logic
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            full_power_state_meta_q <= 1'b0;
            full_power_state_q      <= 1'b0;
        end
        else
        begin
            full_power_state_meta_q <= full_power_state;
            full_power_state_q      <= full_power_state_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    logic                 wr_timeout;
    logic                 wr_disable;
    logic                 wr_freq;
    logic                 timeout_ok;
    logic                 freq_ok;
    logic [TIMEOUT_W-1:0] timeout_q;
    logic [TIMEOUT_W-1:0] count_q;
    logic [31:0]          disable_q;
    logic [FREQ_W-1:0]    freq_q;
    logic [IRQ_W-1:0]     stat_q;
    logic [IRQ_W-1:0]     mask_q;
    logic                 enabled;
    logic                 tick;
    logic                 expire;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
        hit = (a == idx);
    endfunction

    assign wr_timeout = reg_wr && hit(reg_addr, ADDR_TIMEOUT);
    assign wr_disable = reg_wr && hit(reg_addr, ADDR_DISABLE);
    assign wr_freq    = reg_wr && hit(reg_addr, ADDR_FREQ);
    // High half must be the exact complement of the low half
    assign timeout_ok = (reg_wdata[31:16] == ~reg_wdata[15:0]);
    assign freq_ok    = (reg_wdata[6:0] >= FREQ_MIN) && (reg_wdata[6:0] <= FREQ_MAX)
                        && (reg_wdata[31:7] == 25'h0);
    // Any value other than the magic word leaves the watchdog running
    assign enabled    = (disable_q != DISABLE_MAGIC);

    // ------------------------------------------------------------
    // Timeout register
    // ------------------------------------------------------------
    // Malformed writes leave the stored timeout untouched
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            timeout_q <= TIMEOUT_RST;
        else if (wr_timeout && timeout_ok)
            timeout_q <= reg_wdata[15:0];
    end

    // Disable key register, starts at the magic value
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            disable_q <= DISABLE_MAGIC;
        else if (wr_disable)
            disable_q <= reg_wdata;
    end

    // Oscillator frequency; out-of-range writes are ignored
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            freq_q <= FREQ_RST;
        else if (wr_freq && freq_ok)
            freq_q <= reg_wdata[6:0];
    end

    // ------------------------------------------------------------
    // Millisecond prescaler
    // ------------------------------------------------------------
    logic [PRESC_W-1:0] presc_q;
    logic [PRESC_W-1:0] presc_top;

    // Wrong MHz setting stretches or shrinks every tick
    assign presc_top = PRESC_W'(freq_q * CLK_PER_MHZ_MS) - PRESC_W'(1);
    assign tick      = enabled && full_power_state_q && (presc_q >= presc_top);

    // Prescaler frozen outside full power, held at zero while disabled
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            presc_q <= '0;
        else if (!enabled || wr_timeout && timeout_ok)
            presc_q <= '0;
        else if (full_power_state_q)
            presc_q <= tick ? '0 : presc_q + PRESC_W'(1);
    end

    // ------------------------------------------------------------
    // Countdown
    // ------------------------------------------------------------
    // Expiry when the count is at one or zero and one more tick arrives
    assign expire = tick && (count_q <= 16'h0001);

    // Load order matters: a stop or a kick overrides a tick in the same cycle
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            count_q <= COUNT_RST;
        else if (wr_disable && reg_wdata == DISABLE_MAGIC)
            count_q <= timeout_q;
        else if (wr_timeout && timeout_ok)
            count_q <= reg_wdata[15:0];
        else if (expire)
            count_q <= timeout_q;
        else if (tick)
            count_q <= count_q - 16'h0001;
    end

    // ------------------------------------------------------------
    // Tile reset pulse
    // ------------------------------------------------------------
    logic [3:0] trst_cnt_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            trst_cnt_q <= 4'h0;
            tile_reset <= 1'b0;
        end
        else if (expire)
        begin
            trst_cnt_q <= TILE_RST_CYC - 4'h1;
            tile_reset <= 1'b1;
        end
        else if (trst_cnt_q != 4'h0)
            trst_cnt_q <= trst_cnt_q - 4'h1;
        else
            tile_reset <= 1'b0;
    end

    // ------------------------------------------------------------
    // Write answers
    // ------------------------------------------------------------
    // Writes to unchecked registers are always acknowledged
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            reg_ack  <= 1'b0;
            reg_nack <= 1'b0;
        end
        else
        begin
            reg_ack  <= reg_wr && !(wr_timeout && !timeout_ok) && !(wr_freq && !freq_ok);
            reg_nack <= (wr_timeout && !timeout_ok) || (wr_freq && !freq_ok);
        end
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    logic [IRQ_W-1:0] ev;
    logic             rd_stat;

    assign ev      = {reg_nack, expire};
    assign rd_stat = reg_rd && hit(reg_addr, ADDR_IRQ_STAT);

    // Read clears, but an event in the same cycle wins
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            stat_q <= '0;
        else
            stat_q <= (rd_stat ? '0 : stat_q) | ev;
    end

    // Mask bits share the status layout
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            mask_q <= '0;
        else if (reg_wr && hit(reg_addr, ADDR_IRQ_MASK))
            mask_q <= reg_wdata[IRQ_W-1:0];
    end

    // Built from next status so irq drops with the clearing read
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(((rd_stat ? '0 : stat_q) | ev) & mask_q);
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Unmapped addresses read as zero
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 32'h00000000;
        else if (reg_rd)
        begin
            case (reg_addr)
                ADDR_TIMEOUT:  reg_rdata <= {count_q, timeout_q};
                ADDR_DISABLE:  reg_rdata <= disable_q;
                ADDR_FREQ:     reg_rdata <= {25'h0, freq_q};
                ADDR_IRQ_STAT: reg_rdata <= {30'h0, stat_q};
                ADDR_IRQ_MASK: reg_rdata <= {30'h0, mask_q};
                default:       reg_rdata <= 32'h00000000;
            endcase
        end
        else
            reg_rdata <= 32'h00000000;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_bad_wr;
        wr_timeout && !timeout_ok;
    endsequence

    a_bad_nack: assert property (@(posedge sys_clk) disable iff (rst)
        s_bad_wr |=> reg_nack && !reg_ack && $stable(timeout_q))
        else $error("malformed timeout write not refused");

    a_good_kick: assert property (@(posedge sys_clk) disable iff (rst)
        wr_timeout && timeout_ok |=> reg_ack && count_q == $past(reg_wdata[15:0]))
        else $error("accepted timeout did not load counter");

    a_frozen_asleep: assert property (@(posedge sys_clk) disable iff (rst)
        !full_power_state_q && !reg_wr |=> $stable(count_q))
        else $error("counter moved outside full power");

    a_disabled_hold: assert property (@(posedge sys_clk) disable iff (rst)
        !enabled && !reg_wr |=> $stable(count_q) && presc_q == '0)
        else $error("disabled watchdog counted");

    a_tick_decr: assert property (@(posedge sys_clk) disable iff (rst)
        tick && !reg_wr && count_q > 16'h0001 |=> count_q == $past(count_q) - 16'h0001)
        else $error("tick did not decrement");

    a_expire_rst: assert property (@(posedge sys_clk) disable iff (rst)
        expire |=> tile_reset [*8])
        else $error("tile reset not held after expiry");

    a_ro_count: assert property (@(posedge sys_clk) disable iff (rst)
        reg_rd && reg_addr == ADDR_TIMEOUT |=> reg_rdata[31:16] == $past(count_q))
        else $error("count field read wrong");

    a_tick_spacing: assert property (@(posedge sys_clk) disable iff (rst)
        tick |=> !tick [*4])
        else $error("ticks too close");

    a_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
        expire && mask_q[IRQ_EXPIRE] |=> irq)
        else $error("masked-in expiry did not raise interrupt");

    sequence s_magic_wr;
        wr_disable && reg_wdata == DISABLE_MAGIC;
    endsequence

    a_magic_stop: assert property (@(posedge sys_clk) disable iff (rst)
        s_magic_wr |=> !enabled && count_q == $past(timeout_q))
        else $error("magic key did not stop and reload watchdog");

    a_enable_run: assert property (@(posedge sys_clk) disable iff (rst)
        wr_disable && reg_wdata != DISABLE_MAGIC |=> enabled)
        else $error("non-magic key did not enable watchdog");

    a_rst_cause: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(tile_reset) |-> $past(expire))
        else $error("tile reset rose without expiry");

    a_freq_refuse: assert property (@(posedge sys_clk) disable iff (rst)
        wr_freq && !freq_ok |=> reg_nack && $stable(freq_q))
        else $error("bad frequency write not refused");

    a_kick_restart: assert property (@(posedge sys_clk) disable iff (rst)
        wr_timeout && timeout_ok |=> presc_q == '0)
        else $error("kick did not restart prescaler");

endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the millisecond watchdog top level.
// Assumes the register port answers one cycle after each strobe and that
// the frequency register is set to its minimum so that one tick is 5000 clocks.
`timescale 1ns/1ps

module testbench;
    import mswd_pkg::*;

    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic        sys_clk          = 1'b0;
    logic        rst              = 1'b1;
    logic [7:0]  reg_addr         = 8'h00;
    logic [31:0] reg_wdata        = 32'h00000000;
    logic        reg_wr           = 1'b0;
    logic        reg_rd           = 1'b0;
    logic        full_power_state = 1'b0;
    logic [31:0] reg_rdata;
    logic        reg_ack;
    logic        reg_nack;
    logic        tile_reset;
    logic        irq;
    int          error_cnt        = 0;
    int          n_compared       = 0;
    int          cyc              = 0;

    mswd_top i_dut (
        .sys_clk          (sys_clk),
        .rst              (rst),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_wr           (reg_wr),
        .reg_rd           (reg_rd),
        .reg_rdata        (reg_rdata),
        .reg_ack          (reg_ack),
        .reg_nack         (reg_nack),
        .full_power_state (full_power_state),
        .tile_reset       (tile_reset),
        .irq              (irq)
    );

    // 125 MHz system clock
    always #4 sys_clk = ~sys_clk;

    // Hang guard: the full sequence needs about 47000 cycles
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc >= 60000)
        begin
            error_cnt++;
            results();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask

    // One-cycle write, then compare {ack, nack} in the answer cycle
    task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        #1;
        chk("write response", {30'h0, exp}, {30'h0, reg_ack, reg_nack});
    endtask

    // One-cycle read; data stand only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        chk("read data", exp, reg_rdata);
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        int t0;
        int i;
        int n;
        waitc(20);
        rst <= 1'b0;
        // Reset values, unmapped read
        rdc(ADDR_TIMEOUT, 32'h0000_03e8);
        rdc(ADDR_DISABLE, 32'h0d15_ab1e);
        rdc(ADDR_FREQ, 32'h0000_0019);
        rdc(ADDR_IRQ_STAT, 32'h0);
        rdc(ADDR_IRQ_MASK, 32'h0);
        rdc(8'h10, 32'h0);
        // Malformed keyed writes are refused and change neither timeout nor count
        wrc(ADDR_TIMEOUT, 32'h0000_0003, 2'b01);
        wrc(ADDR_TIMEOUT, 32'hfffc_0002, 2'b01);
        rdc(ADDR_TIMEOUT, 32'h0000_03e8);
        // Refusal event is sticky but masked, then unmasked, then cleared by read
        chk("irq masked", 32'h0, {31'h0, irq});
        wrc(ADDR_IRQ_MASK, 32'h0000_0002, 2'b10);
        waitc(2);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        rdc(ADDR_IRQ_STAT, 32'h0000_0002);
        waitc(2);
        chk("irq cleared", 32'h0, {31'h0, irq});
        // Frequency range: out of range and stray upper bits refused
        wrc(ADDR_FREQ, 32'h0000_0004, 2'b01);
        wrc(ADDR_FREQ, 32'h0000_0065, 2'b01);
        wrc(ADDR_FREQ, 32'h0000_0085, 2'b01);
        wrc(ADDR_FREQ, 32'h0000_0005, 2'b10);
        rdc(ADDR_FREQ, 32'h0000_0005);
        rdc(ADDR_IRQ_STAT, 32'h0000_0002);
        wrc(ADDR_IRQ_MASK, 32'h0000_0001, 2'b10);
        // Well-formed write loads timeout and count; upper half not writable
        wrc(ADDR_TIMEOUT, 32'hfffc_0003, 2'b10);
        rdc(ADDR_TIMEOUT, 32'h0003_0003);
        // Disabled out of reset: full_power_state but no counting
        @(posedge sys_clk);
        full_power_state <= 1'b1;
        waitc(6000);
        rdc(ADDR_TIMEOUT, 32'h0003_0003);
        // Enable; one tick of 5 x 1000 clocks takes one count off
        wrc(ADDR_DISABLE, ENABLE_VALUE, 2'b10);
        waitc(5010);
        rdc(ADDR_TIMEOUT, 32'h0002_0003);
        // Not full_power_state: count frozen over two tick periods
        @(posedge sys_clk);
        full_power_state <= 1'b0;
        waitc(10000);
        rdc(ADDR_TIMEOUT, 32'h0002_0003);
        @(posedge sys_clk);
        full_power_state <= 1'b1;
        waitc(5);
        // Kick restarts the countdown from the full timeout
        wrc(ADDR_TIMEOUT, 32'hfffc_0003, 2'b10);
        t0 = cyc;
        rdc(ADDR_TIMEOUT, 32'h0003_0003);
        // Expiry after three ticks resets the tile
        for (i = 0; i < 16000; i++)
        begin
            @(posedge sys_clk);
            #1;
            if (tile_reset === 1'b1)
                break;
        end
        n = cyc - t0;
        chk("expiry delay ok", 32'h1, {31'h0, (n >= 14990 && n <= 15010)});
        chk("irq on expiry", 32'h1, {31'h0, irq});
        // Tile reset pulse length
        n = 0;
        while (tile_reset === 1'b1 && n < 20)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk("tile reset cycles", {28'h0, TILE_RST_CYC}, n);
        rdc(ADDR_IRQ_STAT, 32'h0000_0001);
        // Counting resumes from the reload; magic value reloads and stops
        waitc(5010);
        rdc(ADDR_TIMEOUT, 32'h0002_0003);
        wrc(ADDR_DISABLE, DISABLE_MAGIC, 2'b10);
        rdc(ADDR_TIMEOUT, 32'h0003_0003);
        rdc(ADDR_DISABLE, 32'h0d15_ab1e);
        waitc(6000);
        rdc(ADDR_TIMEOUT, 32'h0003_0003);
        chk("no tile reset when stopped", 32'h0, {31'h0, tile_reset});
        results();
    end

endmodule
